// ### core/ascu_defs.svh
// constants for the asynchronous serial channel
`ifndef ASCU_DEFS_SVH
`define ASCU_DEFS_SVH
`define ASCU_OVS_LAST   4'hF
`define ASCU_OVS_CENTER 4'h8
`define ASCU_DIV8_LAST  5'h07
`define ASCU_DIV32_LAST 5'h1F
`define ASCU_FRAME_W    13
`define ASCU_LINE_IDLE  1'b1
`define ASCU_RST_DATA   9'h000
`define ASCU_MASK7      9'h07F
`define ASCU_MASK8      9'h0FF
`define ASCU_MASK9      9'h1FF
`define ASCU_TWO_CH     2
`endif

// ### core/ascu_pkg.sv
// types shared by the asynchronous serial channel modules
package ascu_pkg;
    typedef enum logic [1:0] {
        ASCU_LEN7 = 2'b00,
        ASCU_LEN8 = 2'b01,
        ASCU_LEN9 = 2'b10
    } ascu_len_t;
    typedef enum logic [1:0] {
        ASCU_HS_OFF = 2'b00,
        ASCU_HS_CTS = 2'b01,
        ASCU_HS_RTS = 2'b10
    } ascu_hs_t;
    typedef enum logic [1:0] {
        ASCU_CK_DIV1  = 2'b00,
        ASCU_CK_DIV8  = 2'b01,
        ASCU_CK_DIV32 = 2'b10
    } ascu_ck_t;
    typedef enum logic {
        ASCU_TX_IDLE = 1'b0,
        ASCU_TX_SEND = 1'b1
    } ascu_tx_st_t;
    typedef enum logic [1:0] {
        ASCU_RX_IDLE  = 2'b00,
        ASCU_RX_START = 2'b01,
        ASCU_RX_BITS  = 2'b10
    } ascu_rx_st_t;
endpackage

// ### core/ascu_baud.sv
// prescaler and n+1 divider giving the 16x oversampling tick
`timescale 1ns/1ps
`include "ascu_defs.svh"
module ascu_baud (
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_n,
    input  wire ascu_pkg::ascu_ck_t i_clk_sel,
    input  wire logic               i_clk_ext,
    input  wire logic               i_ext_ref,
    input  wire logic [7:0]         i_div_n,
    output logic                    o_tick16
);
    import ascu_pkg::*;
    logic [4:0] pre_r;   // free running prescale count
    logic       ext_d_r; // last level of the reference pin
    logic [7:0] div_r;   // down counter of the divider
    // one pulse per prescaled clock, internal or external
    wire ext_edge = i_ext_ref & ~ext_d_r;
    wire int_tick = (i_clk_sel == ASCU_CK_DIV1) |
        ((i_clk_sel == ASCU_CK_DIV8) & (pre_r[2:0] == `ASCU_DIV8_LAST)) |
        ((i_clk_sel == ASCU_CK_DIV32) & (pre_r == `ASCU_DIV32_LAST));
    wire pre_tick = i_clk_ext ? ext_edge : int_tick;
    // counting n down to zero divides by n+1
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pre_r    <= 5'h00;
            ext_d_r  <= 1'b0;
            div_r    <= 8'h00;
            o_tick16 <= 1'b0;
        end else begin
            pre_r    <= pre_r + 5'h01;
            ext_d_r  <= i_ext_ref;
            o_tick16 <= 1'b0;
            if (pre_tick) begin
                if (div_r == 8'h00) begin
                    div_r    <= i_div_n;
                    o_tick16 <= 1'b1;
                end else begin
                    div_r <= div_r - 8'h01;
                end
            end
        end
    end
endmodule

// ### core/ascu_bitclk.sv
// bit strobe: one pulse per sixteen oversampling ticks
`timescale 1ns/1ps
`include "ascu_defs.svh"
module ascu_bitclk (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_tick16,
    input  wire logic       i_restart,
    input  wire logic [3:0] i_phase,
    output logic            o_strobe
);
    logic [3:0] ph_r; // position inside the bit
    // restart aligns the phase, e.g. to the start edge
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ph_r     <= 4'h0;
            o_strobe <= 1'b0;
        end else begin
            o_strobe <= 1'b0;
            if (i_restart) begin
                ph_r <= i_phase;
            end else if (i_tick16) begin
                ph_r     <= ph_r + 4'h1;
                o_strobe <= (ph_r == `ASCU_OVS_LAST);
            end
        end
    end
endmodule

// ### core/ascu_uart.sv
// asynchronous serial channel, uart mode, top level
`timescale 1ns/1ps
`include "ascu_defs.svh"
// Contract
// - characters carry seven, eight or nine bits
// - one start bit, one or two stops
// - parity odd, even or none
// - internal clock over sixteen times n+1
// - external clock over sixteen times n+1, on channels zero and one
// - divider n is eight bits wide
// - handshake is cts, rts or off
// - send needs enable, data and cts low
// - receive needs enable and a start bit
// - select 0 interrupts on buffer to shifter
// - select 1 interrupts after character sent
// - receive interrupt when buffer gets character
// - overrun when unread buffer gets new character
// - overrun overwrites buffer, interrupt unchanged
// - framing error on missing stop bit
// - parity error on wrong count of ones
// - error sum set by any error
// - sleep mode on channels zero and one
// - sleep keeps only characters with msb set
// - data inversion spares start, parity, stop
// - inversion at buffer write and read
// - pin polarity inverts every line level
// - idle output high, floating if open drain
module ascu_uart #(
    parameter int CHANNEL = 0 // channel number, 0 to 2
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_n,
    input  wire ascu_pkg::ascu_len_t i_char_len,
    input  wire logic                i_two_stop,
    input  wire logic                i_parity_en,
    input  wire logic                i_parity_odd,
    input  wire ascu_pkg::ascu_ck_t  i_clk_sel,
    input  wire logic                i_clk_ext,
    input  wire logic                i_transfer_clock_pin,
    input  wire logic [7:0]          i_brg_n,
    input  wire ascu_pkg::ascu_hs_t  i_hs_mode,
    input  wire logic                i_tx_en,
    input  wire logic                i_rx_en,
    input  wire logic                i_tx_irq_sel,
    input  wire logic                i_sleep,
    input  wire logic                i_data_inv,
    input  wire logic                i_pol_inv,
    input  wire logic                i_open_drain,
    input  wire logic                i_tx_wr,
    input  wire logic [8:0]          i_tx_data,
    input  wire logic                i_rx_rd,
    input  wire logic                i_serial_in_pin,
    input  wire logic                i_cts_n,
    output logic                     o_serial_out_pin,
    output logic                     o_serial_out_oe,
    output logic                     o_rts_n,
    output logic                     o_tx_empty,
    output logic                     o_tx_busy,
    output logic                     o_tx_irq,
    output logic [8:0]               o_rx_data,
    output logic                     o_rx_full,
    output logic                     o_rx_irq,
    output logic                     o_overrun,
    output logic                     o_framing,
    output logic                     o_parity_err,
    output logic                     o_err_sum
);
    import ascu_pkg::*;
    // number of data bits of a character
    function automatic logic [3:0] len_bits(input ascu_len_t l);
        unique case (l)
            ASCU_LEN7: len_bits = 4'h7;
            ASCU_LEN8: len_bits = 4'h8;
            ASCU_LEN9: len_bits = 4'h9;
            default:   len_bits = 4'h8; // illegal code acts as 8
        endcase
    endfunction
    // mask of the data bits of a character
    function automatic logic [8:0] len_mask(input ascu_len_t l);
        unique case (l)
            ASCU_LEN7: len_mask = `ASCU_MASK7;
            ASCU_LEN8: len_mask = `ASCU_MASK8;
            ASCU_LEN9: len_mask = `ASCU_MASK9;
            default:   len_mask = `ASCU_MASK8;
        endcase
    endfunction
    // lsb first: start 0, data, parity, then ones for stops
    function automatic logic [`ASCU_FRAME_W-1:0] frame_of(
        input logic [8:0] d, input ascu_len_t l,
        input logic pen, input logic podd);
        logic [`ASCU_FRAME_W-1:0] f;
        logic [3:0]               nb;
        f    = '1;
        nb   = len_bits(l);
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nb)) f[i+1] = d[i];
        end
        if (pen) f[nb+4'h1] = ^(d & len_mask(l)) ^ podd;
        return f;
    endfunction
    // channel features present only on some channels
    localparam logic IS_TWO = (CHANNEL == `ASCU_TWO_CH);
    wire ext_ok   = i_clk_ext & ~IS_TWO;
    wire sleep_on = i_sleep & ~IS_TWO;
    wire dinv_on  = i_data_inv & IS_TWO;
    wire pinv_on  = i_pol_inv & IS_TWO;
    wire [3:0] nb    = len_bits(i_char_len);
    wire [8:0] dmask = len_mask(i_char_len);
    wire [8:0] dflip = dinv_on ? dmask : 9'h000;
    logic tick16;     // 16x oversampling tick
    logic tx_strobe;  // transmit bit boundary
    logic rx_strobe;  // receive bit centre
    // the external reference arrives on the transfer clock pin
    ascu_baud u_baud (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_clk_sel  (i_clk_sel),
        .i_clk_ext  (ext_ok),
        .i_ext_ref  (i_transfer_clock_pin),
        .i_div_n    (i_brg_n),
        .o_tick16   (tick16)
    );
    // ---------------- transmitter ----------------
    ascu_tx_st_t              tx_st_r;    // transmit state
    logic [8:0]               tx_buf_r;   // transmit buffer
    logic [`ASCU_FRAME_W-1:0] tx_sh_r;    // transmit shifter
    logic [3:0]               tx_left_r;  // bits still to send
    logic                     tx_empty_r; // buffer empty flag
    wire cts_ok  = (i_hs_mode != ASCU_HS_CTS) | ~i_cts_n;
    wire tx_go   = (tx_st_r == ASCU_TX_IDLE) & i_tx_en &
                   ~tx_empty_r & cts_ok;
    wire tx_last = (tx_st_r == ASCU_TX_SEND) & tx_strobe &
                   (tx_left_r == 4'h1);
    wire [3:0] tx_cnt = 4'(nb + {3'h0, i_parity_en} +
                        {3'h0, i_two_stop} + 4'h2);
    wire tx_bit  = (tx_st_r == ASCU_TX_SEND) ? tx_sh_r[0]
                                             : `ASCU_LINE_IDLE;
    wire tx_lvl  = tx_bit ^ pinv_on;
    ascu_bitclk u_txclk (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_tick16   (tick16),
        .i_restart  (tx_go),
        .i_phase    (4'h0),
        .o_strobe   (tx_strobe)
    );
    // buffer write, load into shifter, bit shifting
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_st_r    <= ASCU_TX_IDLE;
            tx_buf_r   <= `ASCU_RST_DATA;
            tx_sh_r    <= '1;
            tx_left_r  <= 4'h0;
            tx_empty_r <= 1'b1;
        end else begin
            if (tx_go) begin
                tx_st_r    <= ASCU_TX_SEND;
                tx_sh_r    <= frame_of(tx_buf_r, i_char_len,
                                       i_parity_en, i_parity_odd);
                tx_left_r  <= tx_cnt;
                tx_empty_r <= 1'b1;
            end else if (tx_strobe && tx_st_r == ASCU_TX_SEND) begin
                tx_sh_r   <= {1'b1, tx_sh_r[`ASCU_FRAME_W-1:1]};
                tx_left_r <= tx_left_r - 4'h1;
                if (tx_last) tx_st_r <= ASCU_TX_IDLE;
            end
            // a write in the load cycle still leaves data pending
            if (i_tx_wr) begin
                tx_buf_r   <= (i_tx_data ^ dflip) & dmask;
                tx_empty_r <= 1'b0;
            end
        end
    end
    // pin, interrupt and status flops
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_serial_out_pin <= 1'b1;
            o_serial_out_oe  <= 1'b1;
            o_tx_irq         <= 1'b0;
            o_tx_empty       <= 1'b1;
            o_tx_busy        <= 1'b0;
        end else begin
            o_serial_out_pin <= tx_lvl;
            // open drain only pulls low, high floats
            o_serial_out_oe  <= ~(i_open_drain & tx_lvl);
            o_tx_irq <= i_tx_irq_sel ? tx_last
                                     : tx_go;
            o_tx_empty <= (tx_empty_r | tx_go) & ~i_tx_wr;
            o_tx_busy  <= (tx_st_r == ASCU_TX_SEND | tx_go) & ~tx_last;
        end
    end
    // ---------------- receiver ----------------
    ascu_rx_st_t rx_st_r;    // receive state
    logic        rx_prev_r;  // line level one cycle ago
    logic [8:0]  rx_dat_r;   // data bits gathered
    logic        rx_par_r;   // parity bit gathered
    logic        rx_fbad_r;  // a stop bit was low
    logic [3:0]  rx_idx_r;   // bits taken after start
    wire rx_line  = i_serial_in_pin ^ pinv_on;
    wire rx_fall  = rx_prev_r & ~rx_line;
    wire rx_begin = (rx_st_r == ASCU_RX_IDLE) & i_rx_en &
                    rx_fall;
    wire rx_take  = (rx_st_r == ASCU_RX_BITS) & rx_strobe;
    wire [3:0] rx_total = 4'(nb + {3'h0, i_parity_en} +
                          {3'h0, i_two_stop} + 4'h1);
    wire is_par   = i_parity_en & (rx_idx_r == nb);
    wire is_stop  = rx_idx_r >= 4'(nb + {3'h0, i_parity_en});
    wire rx_done  = rx_take & (rx_idx_r == rx_total - 4'h1);
    wire fr_err   = rx_fbad_r | (is_stop & ~rx_line);
    wire par_err  = i_parity_en &
        (^(rx_dat_r & dmask) ^ rx_par_r ^ i_parity_odd);
    wire msb      = rx_dat_r[nb-4'h1];
    wire rx_keep  = rx_done & ~(sleep_on & ~msb);
    wire ovr      = rx_keep & o_rx_full & ~i_rx_rd;
    // centre phase makes the first strobe mid start bit
    ascu_bitclk u_rxclk (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_tick16   (tick16),
        .i_restart  (rx_begin),
        .i_phase    (`ASCU_OVS_CENTER),
        .o_strobe   (rx_strobe)
    );
    // start check, bit gathering; disable aborts a frame
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rx_st_r   <= ASCU_RX_IDLE;
            rx_prev_r <= 1'b1;
            rx_dat_r  <= `ASCU_RST_DATA;
            rx_par_r  <= 1'b0;
            rx_fbad_r <= 1'b0;
            rx_idx_r  <= 4'h0;
        end else begin
            rx_prev_r <= rx_line;
            unique case (rx_st_r)
                ASCU_RX_IDLE: begin
                    if (rx_begin) rx_st_r <= ASCU_RX_START;
                end
                ASCU_RX_START: begin
                    // a glitch that is high at centre is no start
                    if (rx_strobe) begin
                        rx_st_r   <= rx_line ? ASCU_RX_IDLE
                                             : ASCU_RX_BITS;
                        rx_dat_r  <= `ASCU_RST_DATA;
                        rx_fbad_r <= 1'b0;
                        rx_idx_r  <= 4'h0;
                    end
                end
                ASCU_RX_BITS: begin
                    if (rx_take) begin
                        if (rx_idx_r < nb) rx_dat_r[rx_idx_r] <= rx_line;
                        if (is_par) rx_par_r <= rx_line;
                        if (is_stop && !rx_line) rx_fbad_r <= 1'b1;
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_done) rx_st_r <= ASCU_RX_IDLE;
                    end
                end
                default: rx_st_r <= ASCU_RX_IDLE;
            endcase
            if (!i_rx_en) rx_st_r <= ASCU_RX_IDLE;
        end
    end
    // receive buffer and flags; a new event beats a clear
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_rx_data    <= `ASCU_RST_DATA;
            o_rx_full    <= 1'b0;
            o_rx_irq     <= 1'b0;
            o_overrun    <= 1'b0;
            o_framing    <= 1'b0;
            o_parity_err <= 1'b0;
            o_err_sum    <= 1'b0;
            o_rts_n      <= 1'b1;
        end else begin
            o_rx_irq <= rx_keep & ~ovr;
            if (i_rx_rd) o_rx_full <= 1'b0;
            if (!i_rx_en) begin
                o_overrun    <= 1'b0;
                o_framing    <= 1'b0;
                o_parity_err <= 1'b0;
                o_err_sum    <= 1'b0;
            end
            if (rx_keep) begin
                o_rx_data <= rx_dat_r ^ dflip;
                o_rx_full <= 1'b1;
                if (ovr) o_overrun <= 1'b1;
                if (fr_err) o_framing <= 1'b1;
                if (par_err) o_parity_err <= 1'b1;
                if (ovr | fr_err | par_err) o_err_sum <= 1'b1;
            end
            // rts low while a character can be taken
            o_rts_n <= ~((i_hs_mode == ASCU_HS_RTS) & i_rx_en &
                         ~o_rx_full);
        end
    end
    // ---------------- checks ----------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_tx_start;
        $rose(tx_st_r == ASCU_TX_SEND) |->
            $past(i_tx_en) && $past(!tx_empty_r) &&
            ($past(i_hs_mode) != ASCU_HS_CTS || $past(!i_cts_n));
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("transmit began without its conditions");
    property p_irq_load;
        tx_go && !i_tx_irq_sel |=> o_tx_irq;
    endproperty
    a_irq_load: assert property (p_irq_load)
        else $error("no transmit interrupt at load");
    property p_irq_done;
        tx_last && i_tx_irq_sel |=> o_tx_irq && !o_tx_busy;
    endproperty
    a_irq_done: assert property (p_irq_done)
        else $error("no transmit interrupt at end of frame");
    property p_start_low;
        tx_go && !pinv_on |=> ##1 !o_serial_out_pin;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start bit not driven low");
    property p_idle_high;
        (tx_st_r == ASCU_TX_IDLE && !pinv_on)[*2] |-> o_serial_out_pin;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("idle line not high");
    property p_rx_gate;
        rx_st_r == ASCU_RX_IDLE ##1 rx_st_r == ASCU_RX_START |->
            $past(i_rx_en) && $past(rx_fall);
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("reception began without enable and edge");
    property p_rx_irq;
        o_rx_irq |-> o_rx_full && !$past(o_rx_full && !i_rx_rd);
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("receive interrupt with wrong buffer state");
    property p_overrun;
        ovr && i_rx_en |=> o_overrun && !o_rx_irq && o_err_sum;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not handled");
    property p_err_sum;
        (o_framing || o_parity_err || o_overrun) |-> o_err_sum;
    endproperty
    a_err_sum: assert property (p_err_sum)
        else $error("error sum missing");
    property p_sleep;
        rx_done && sleep_on && !msb && !i_rx_rd |=>
            $stable(o_rx_full) && !o_rx_irq;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep mode took a character");
    property p_rts_off;
        i_hs_mode != ASCU_HS_RTS |=> o_rts_n;
    endproperty
    a_rts_off: assert property (p_rts_off)
        else $error("rts driven while not selected");
    c_tx_frame: cover property (tx_go ##[1:1000] tx_last);
    c_rx_char: cover property (rx_begin ##[1:1000] rx_keep);
    c_rx_ovr: cover property (ovr);
    c_rx_frm: cover property (rx_done && fr_err);
endmodule

// ### sim/ascu_peer.sv
// far-side serial node: frame sender and frame catcher
`timescale 1ns/1ps
module ascu_peer #(
    parameter int BIT = 16 // core cycles per bit
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_go,      // start sending i_frame
    input  wire logic [12:0] i_frame,   // start bit in bit 0
    input  wire logic [3:0]  i_nbits,   // bits per frame
    input  wire logic        i_line_in, // line from the channel
    output logic             o_line,    // line into the channel
    output logic             o_rx_busy, // frame being caught
    output logic [12:0]      o_got      // caught bits, last on top
);
    int          tx_cnt  = 0;   // cycles left in outgoing frame
    int          rx_cnt  = 0;   // cycles to next sample
    int          rx_left = 0;   // samples still to take
    logic [12:0] tx_sh   = '1;  // ones shift in, so line idles high
    logic        prev    = 1'b1; // line one cycle ago
    assign o_line    = tx_sh[0];
    assign o_rx_busy = (rx_left != 0);
    // sender: each bit stands BIT cycles, lsb first
    always @(posedge i_core_clk) begin
        if (i_go) begin
            tx_sh  <= i_frame;
            tx_cnt <= i_nbits * BIT;
        end else if (tx_cnt != 0) begin
            tx_cnt <= tx_cnt - 1;
            if (tx_cnt % BIT == 1)
                tx_sh <= {1'b1, tx_sh[12:1]};
        end
    end
    // catcher: a falling edge starts it, samples near bit centres
    always @(posedge i_core_clk) begin
        prev <= i_line_in;
        if (rx_left == 0) begin
            if (prev && !i_line_in) begin
                rx_left <= i_nbits;
                rx_cnt  <= BIT / 2 - 1;
            end
        end else if (rx_cnt == 0) begin
            o_got   <= {i_line_in, o_got[12:1]};
            rx_left <= rx_left - 1;
            rx_cnt  <= BIT - 1;
        end else begin
            rx_cnt <= rx_cnt - 1;
        end
    end
endmodule

// ### sim/test_ascu_uart.sv
// self-checking bench for the uart-mode serial channel
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %0h seen %0h", nm, e, g); \
    n_fail++; end end
module test_ascu_uart;
    import ascu_pkg::*;
    int          n_tests = 0, n_fail = 0;
    logic        i_core_clk = 0, i_rst_n = 0, i_two_stop = 0;
    ascu_len_t   i_char_len = ASCU_LEN8;
    ascu_ck_t    i_clk_sel = ASCU_CK_DIV1;
    ascu_hs_t    i_hs_mode = ASCU_HS_OFF;
    logic        i_parity_en = 0, i_parity_odd = 0, i_tx_en = 0;
    logic        i_rx_en = 0, i_tx_irq_sel = 0, i_sleep = 0;
    logic        i_open_drain = 0, i_tx_wr = 0, i_rx_rd = 0, i_cts_n = 1;
    logic [7:0]  i_brg_n = 8'h00; // n = 0: sixteen cycles a bit
    logic        i_clk_ext = 0, i_transfer_clock_pin = 0;
    int          n_cyc; // cycles counted by a scenario
    logic [8:0]  i_tx_data = 9'h000;
    logic        i_serial_in_pin, o_serial_out_pin, o_serial_out_oe;
    logic        o_rts_n, o_tx_empty, o_tx_busy, o_tx_irq, o_rx_full;
    logic        o_rx_irq, o_overrun, o_framing, o_parity_err, o_err_sum;
    logic [8:0]  o_rx_data;
    logic        p_go = 0, p_rx_busy;
    logic [12:0] p_frame = '1, p_got;
    logic [3:0]  p_nbits = 4'h0;
    // channel-two inversions have no effect on channel 0
    ascu_uart #(.CHANNEL(0)) dut (.i_core_clk, .i_rst_n, .i_char_len,
        .i_two_stop, .i_parity_en, .i_parity_odd, .i_clk_sel,
        .i_clk_ext, .i_transfer_clock_pin, .i_brg_n,
        .i_hs_mode, .i_tx_en, .i_rx_en, .i_tx_irq_sel, .i_sleep,
        .i_data_inv(1'b0), .i_pol_inv(1'b0), .i_open_drain, .i_tx_wr,
        .i_tx_data, .i_rx_rd, .i_serial_in_pin, .i_cts_n,
        .o_serial_out_pin, .o_serial_out_oe, .o_rts_n, .o_tx_empty,
        .o_tx_busy, .o_tx_irq, .o_rx_data, .o_rx_full, .o_rx_irq,
        .o_overrun, .o_framing, .o_parity_err, .o_err_sum);
    ascu_peer #(.BIT(16)) peer (.i_core_clk, .i_go(p_go),
        .i_frame(p_frame), .i_nbits(p_nbits),
        .i_line_in(o_serial_out_pin), .o_line(i_serial_in_pin),
        .o_rx_busy(p_rx_busy), .o_got(p_got));
    // clock: 40 ns period
    initial begin
        forever #20 i_core_clk = ~i_core_clk;
    end
    // far-side reference at half the core rate, for external mode
    always @(posedge i_core_clk) begin
        #1 i_transfer_clock_pin = ~i_transfer_clock_pin;
    end
    // inputs move 1 ns after the edge, outputs read there too
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bound on every open wait
    task automatic guard(input int c);
        if (c > 600) begin
            n_fail++;
            end_of_test;
        end
    endtask
    // expected frame from the live format settings, k = bit count
    function automatic logic [12:0] mkf(input logic [8:0] d, output int k);
        int n;
        logic [12:0] f;
        logic p;
        n = (i_char_len == ASCU_LEN7) ? 7 : (i_char_len == ASCU_LEN9) ? 9 : 8;
        f = '1;
        f[0] = 1'b0;
        p = i_parity_odd; // odd wants an odd count of ones
        for (int i = 0; i < n; i++) begin
            f[i + 1] = d[i];
            p = p ^ d[i];
        end
        if (i_parity_en)
            f[n + 1] = p;
        k = n + 2 + int'(i_parity_en) + int'(i_two_stop);
        return f;
    endfunction
    // load the transmit buffer
    task automatic send(input logic [8:0] d);
        int k;
        p_frame = mkf(d, k);
        p_nbits = 4'(k);
        i_tx_data = d;
        i_tx_wr = 1'b1;
        tick(1);
        i_tx_wr = 1'b0;
    endtask
    // wait for the interrupt and the whole frame, then compare
    task automatic fin(input logic [8:0] d);
        int c, k;
        logic [12:0] f;
        f = mkf(d, k);
        for (c = 0; o_tx_irq !== 1'b1; c++) begin
            tick(1);
            guard(c);
        end
        `CHK("tx irq early", !i_tx_irq_sel, c < 4)
        for (c = 0; p_rx_busy !== 1'b0 || o_tx_busy !== 1'b0; c++) begin
            tick(1);
            guard(c);
        end
        `CHK("tx frame", f & 13'((1 << k) - 1), p_got >> (13 - k))
        `CHK("tx empty", 1'b1, o_tx_empty)
    endtask
    // peer sends d, bit k-flip inverted when flip > 0
    task automatic rx(input logic [8:0] d, input int flip, input logic ex);
        int k;
        logic seen;
        seen = 1'b0;
        p_frame = mkf(d, k);
        if (flip > 0)
            p_frame[k - flip] = ~p_frame[k - flip];
        p_nbits = 4'(k);
        p_go = 1'b1;
        tick(1);
        p_go = 1'b0;
        repeat (k * 16 + 24) begin
            tick(1);
            if (o_rx_irq === 1'b1)
                seen = 1'b1;
        end
        `CHK("rx irq", ex, seen)
    endtask
    // read the buffer and drop the error flags
    task automatic clr;
        i_rx_rd = 1'b1;
        i_rx_en = 1'b0;
        tick(1);
        i_rx_rd = 1'b0;
        i_rx_en = 1'b1;
        tick(1);
    endtask
    initial begin
        tick(3);
        i_rst_n = 1'b1;
        `CHK("idle line", 1'b1, o_serial_out_pin)
        `CHK("idle oe", 1'b1, o_serial_out_oe)
        i_open_drain = 1'b1;
        tick(2);
        `CHK("drain float", 1'b0, o_serial_out_oe)
        i_open_drain = 1'b0;
        i_tx_en = 1'b1;
        i_rx_en = 1'b1;
        $display("test idle done");
        for (int t = 0; t < 3; t++) begin
            i_char_len = ascu_len_t'(t);
            i_parity_en = (t != 0);
            i_parity_odd = (t == 2);
            i_two_stop = (t == 1);
            i_tx_irq_sel = t[0];
            send(9'h1A5);
            fin(9'h1A5);
            rx(9'h1A5, 0, 1'b1);
            `CHK("rx data", 9'h1A5 & (9'h1FF >> (2 - t)), o_rx_data)
            clr;
        end
        $display("test formats done");
        i_char_len = ASCU_LEN8;
        i_parity_odd = 1'b0;
        rx(9'h033, 2, 1'b1);
        `CHK("parity", 1'b1, o_parity_err)
        `CHK("sum", 1'b1, o_err_sum)
        clr;
        rx(9'h044, 1, 1'b1);
        `CHK("framing", 1'b1, o_framing)
        clr;
        rx(9'h011, 0, 1'b1);
        rx(9'h022, 0, 1'b0);
        `CHK("overrun", 1'b1, o_overrun)
        `CHK("ovr data", 9'h022, o_rx_data)
        `CHK("ovr full", 1'b1, o_rx_full)
        i_hs_mode = ASCU_HS_RTS;
        tick(2);
        `CHK("rts full", 1'b1, o_rts_n)
        clr;
        `CHK("rts free", 1'b0, o_rts_n)
        `CHK("sum clear", 1'b0, o_err_sum)
        $display("test errors done");
        i_sleep = 1'b1;
        rx(9'h012, 0, 1'b0);
        `CHK("sleep kept", 9'h022, o_rx_data)
        `CHK("sleep full", 1'b0, o_rx_full)
        rx(9'h092, 0, 1'b1);
        `CHK("sleep data", 9'h092, o_rx_data)
        i_sleep = 1'b0;
        i_hs_mode = ASCU_HS_CTS;
        i_tx_irq_sel = 1'b0;
        send(9'h05A);
        tick(40);
        `CHK("cts hold", 1'b0, o_tx_busy)
        `CHK("cts pend", 1'b0, o_tx_empty)
        i_cts_n = 1'b0;
        fin(9'h05A);
        i_clk_ext = 1'b1;
        send(9'h05B);
        tick(2);
        for (n_cyc = 0; o_serial_out_pin === 1'b0; n_cyc++) begin
            tick(1);
            guard(n_cyc);
        end
        // sixteen reference edges a bit, one edge per two cycles
        `CHK("ext rate", 1'b1, n_cyc > 28 && n_cyc < 36)
        for (n_cyc = 0; o_tx_busy !== 1'b0; n_cyc++) begin
            tick(1);
            guard(n_cyc);
        end
        i_clk_ext = 1'b0;
        $display("test flow done");
        end_of_test;
    end
    // hang cut
    initial begin
        #2400000;
        n_fail++;
        end_of_test;
    end
endmodule
